// *** ldi_led_i2c_target.sv ***
// serial write target and register bank of the dual display led driver
`timescale 1ns/1ps

// Notes on behaviour
// - data changes only while clock low
// - data falling, clock high: start
// - data rising, clock high: stop
// - bus busy from start until stop
// - repeated start restarts address phase
// - eight bits msb first, then ack
// - device pulls data low ninth pulse
// - first byte: address then direction bit
// - answer only to address 36h
// - second byte register, third byte data
// - registers at 10h, A0h, B0h, C0h
// - power-on values 20h, E0h, E0h, FCh
// - general bits 7..5 fixed 001
// - bit 0 enables main display sinks
// - bit 1 enables aux lighting sinks
// - bit 2 enables indicator driver
// - bit 3 enables fifth main sense
// - bit 4 enables third aux sink
// - high reset input enables device
// - bank a/b: five bit code
// - bank c: two bit level
module ldi_led_i2c_target #(
    parameter int FILT_LEN = ldi_pkg::LDI_FILT_LEN
) (
    input  wire logic                            clk,
    input  wire logic                            rst_b,
    input  wire logic                            ce,
    input  wire logic                            scl,
    input  wire logic                            sda_i,
    output logic                                 sda_o,
    output logic                                 sda_oe,
    output logic                                 bus_busy,
    output logic                                 main_display_sink_enable,
    output logic                                 aux_lighting_sink_enable,
    output logic                                 indicator_sink_enable,
    output logic                                 fifth_main_sink_sense_enable,
    output logic                                 third_aux_sink_enable,
    output logic [ldi_pkg::LDI_CODE_W-1:0]       main_brightness_code,
    output logic [ldi_pkg::LDI_CODE_W-1:0]       aux_brightness_code,
    output logic [ldi_pkg::LDI_LEVEL_W-1:0]      indicator_level_code
);

    // ==========================================================
    // link domain: clocked by the serial clock
    logic [1:0]                    lrst_q;
    logic                          link_rst_b;
    logic                          hi_q;
    logic [3:0]                    cnt_q;
    logic [7:0]                    sh_q;
    logic                          restart_q;
    logic                          oe_q;
    ldi_pkg::ldi_link_state_type   state_q;
    logic [7:0]                    reg_sel_q;
    logic [7:0]                    wr_addr_q;
    logic [7:0]                    wr_data_q;
    logic                          wr_tgl_q;
    logic                          start_ev;
    logic                          byte_done;
    logic                          ack_done;

    // reset brought into the link domain over two flops
    always_ff @(posedge scl) begin
        lrst_q <= {lrst_q[0], rst_b};
    end
    assign link_rst_b = lrst_q[1];

    // sample data at the rising clock edge, bits msb first
    // sampling on rise
    always_ff @(posedge scl) begin
        if (!link_rst_b) begin
            hi_q  <= 1'b1;
            cnt_q <= 4'h0;
            sh_q  <= 8'h00;
        end else begin
            hi_q <= sda_i;
            if (restart_q) begin
                cnt_q <= 4'h1;
                sh_q  <= {7'h00, sda_i};
            end else if (cnt_q == ldi_pkg::LDI_BYTE_BITS) begin
                cnt_q <= ldi_pkg::LDI_ACK_SLOT;  // ninth pulse carries the ack
            end else begin
                cnt_q <= cnt_q + 4'h1;
                sh_q  <= {sh_q[6:0], sda_i};
            end
        end
    end

    // start seen at the falling edge that follows it
    // start and restart
    assign start_ev  = (hi_q & ~sda_i) |
                       ((state_q == ldi_pkg::LDI_IDLE) & ~sda_i);
    assign byte_done = (cnt_q == ldi_pkg::LDI_BYTE_BITS);
    assign ack_done  = (cnt_q == ldi_pkg::LDI_ACK_SLOT);

    // byte sequencer and ack driver, acts on falling edges
    always_ff @(negedge scl) begin
        if (!link_rst_b) begin
            state_q   <= ldi_pkg::LDI_IDLE;
            oe_q      <= 1'b0;
            restart_q <= 1'b0;
            reg_sel_q <= 8'h00;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            wr_tgl_q  <= 1'b0;
        end else begin
            restart_q <= 1'b0;
            if (start_ev) begin
                state_q   <= ldi_pkg::LDI_ADDR;
                oe_q      <= 1'b0;
                restart_q <= 1'b1;
            end else begin
                case (state_q)
                    ldi_pkg::LDI_ADDR: begin
                        if (byte_done) begin
                            if (sh_q[7:1] == ldi_pkg::LDI_DEV_ADDR && !sh_q[0]) begin
                                oe_q    <= 1'b1;
                                state_q <= ldi_pkg::LDI_ADDR_ACK;
                            end else begin
                                state_q <= ldi_pkg::LDI_IGNORE;
                            end
                        end
                    end
                    ldi_pkg::LDI_ADDR_ACK: begin
                        if (ack_done) begin
                            oe_q    <= 1'b0;
                            state_q <= ldi_pkg::LDI_REG;
                        end
                    end
                    ldi_pkg::LDI_REG: begin
                        if (byte_done) begin
                            reg_sel_q <= sh_q;
                            oe_q      <= 1'b1;
                            state_q   <= ldi_pkg::LDI_REG_ACK;
                        end
                    end
                    ldi_pkg::LDI_REG_ACK: begin
                        if (ack_done) begin
                            oe_q    <= 1'b0;
                            state_q <= ldi_pkg::LDI_DATA;
                        end
                    end
                    ldi_pkg::LDI_DATA: begin
                        if (byte_done) begin
                            wr_addr_q <= reg_sel_q;
                            wr_data_q <= sh_q;
                            wr_tgl_q  <= ~wr_tgl_q;
                            oe_q      <= 1'b1;
                            state_q   <= ldi_pkg::LDI_DATA_ACK;
                        end
                    end
                    ldi_pkg::LDI_DATA_ACK: begin
                        if (ack_done) begin
                            oe_q    <= 1'b0;
                            state_q <= ldi_pkg::LDI_IDLE;
                        end
                    end
                    ldi_pkg::LDI_IGNORE: begin
                        oe_q <= 1'b0;  // released until the next start
                    end
                    ldi_pkg::LDI_IDLE: begin
                        oe_q <= 1'b0;
                    end
                    default: begin
                        oe_q    <= 1'b0;
                        state_q <= ldi_pkg::LDI_IDLE;
                    end
                endcase
            end
        end
    end

    // ack pulls low while master releases
    assign sda_oe = oe_q;

    // ==========================================================
    // system domain: line monitor and register bank
    logic [1:0]               scl_s_q;
    logic [1:0]               sda_s_q;
    logic [FILT_LEN-1:0]      scl_h_q;
    logic [FILT_LEN-1:0]      sda_h_q;
    logic                     scl_f_q;
    logic                     sda_f_q;
    logic                     scl_p_q;
    logic                     sda_p_q;
    logic                     busy_q;
    logic [2:0]               wt_s_q;
    logic                     wr_pulse;
    logic                     start_det;
    logic                     stop_det;
    logic [ldi_pkg::LDI_GP_EN_W-1:0]  gp_en_q;
    logic [ldi_pkg::LDI_CODE_W-1:0]   main_code_q;
    logic [ldi_pkg::LDI_CODE_W-1:0]   aux_code_q;
    logic [ldi_pkg::LDI_LEVEL_W-1:0]  ind_code_q;

    // a level changes only once all samples agree
    function automatic logic filt_next(input logic [FILT_LEN-1:0] h, input logic cur);
        if (h == {FILT_LEN{1'b1}}) begin
            filt_next = 1'b1;
        end else if (h == {FILT_LEN{1'b0}}) begin
            filt_next = 1'b0;
        end else begin
            filt_next = cur;
        end
    endfunction : filt_next

    // two-flop synchronisers, then sample history and filter
    // sync and filter
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_h_q <= {FILT_LEN{1'b1}};
            sda_h_q <= {FILT_LEN{1'b1}};
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else if (ce) begin
            scl_s_q <= {scl_s_q[0], scl};
            sda_s_q <= {sda_s_q[0], sda_i};
            scl_h_q <= {scl_h_q[FILT_LEN-2:0], scl_s_q[1]};
            sda_h_q <= {sda_h_q[FILT_LEN-2:0], sda_s_q[1]};
            // clock counts high only once steady, so short bit pulses never frame a condition
            scl_f_q <= &scl_h_q;
            sda_f_q <= filt_next(sda_h_q, sda_f_q);
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end

    assign start_det = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
    assign stop_det  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
        end else if (ce) begin
            if (start_det) begin
                busy_q <= 1'b1;
            end else if (stop_det) begin
                busy_q <= 1'b0;
            end
        end
    end

    // write toggle crossing; address and data stand still meanwhile
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wt_s_q <= 3'h0;
        end else if (ce) begin
            wt_s_q <= {wt_s_q[1:0], wr_tgl_q};
        end
    end
    assign wr_pulse = wt_s_q[2] ^ wt_s_q[1];

    // register bank, reset held while the reset input is low
    // decode and power-on
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gp_en_q     <= ldi_pkg::LDI_RST_GENERAL[ldi_pkg::LDI_GP_EN_W-1:0];
            main_code_q <= ldi_pkg::LDI_RST_BANK_A[ldi_pkg::LDI_CODE_W-1:0];
            aux_code_q  <= ldi_pkg::LDI_RST_BANK_B[ldi_pkg::LDI_CODE_W-1:0];
            ind_code_q  <= ldi_pkg::LDI_RST_BANK_C[ldi_pkg::LDI_LEVEL_W-1:0];
        end else if (ce && wr_pulse) begin
            case (wr_addr_q)
                ldi_pkg::LDI_REG_GENERAL: gp_en_q <= wr_data_q[ldi_pkg::LDI_GP_EN_W-1:0];
                ldi_pkg::LDI_REG_BANK_A: main_code_q <= wr_data_q[ldi_pkg::LDI_CODE_W-1:0];
                ldi_pkg::LDI_REG_BANK_B: aux_code_q <= wr_data_q[ldi_pkg::LDI_CODE_W-1:0];
                ldi_pkg::LDI_REG_BANK_C: ind_code_q <= wr_data_q[ldi_pkg::LDI_LEVEL_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // data pin only ever pulls low
    always_ff @(posedge clk) begin
        sda_o <= 1'b0;
    end

    assign main_display_sink_enable     = gp_en_q[ldi_pkg::LDI_GP_MAIN_BIT];
    assign aux_lighting_sink_enable     = gp_en_q[ldi_pkg::LDI_GP_AUX_BIT];
    assign indicator_sink_enable        = gp_en_q[ldi_pkg::LDI_GP_IND_BIT];
    assign fifth_main_sink_sense_enable = gp_en_q[ldi_pkg::LDI_GP_SENSE_BIT];
    assign third_aux_sink_enable        = gp_en_q[ldi_pkg::LDI_GP_THIRD_BIT];
    assign main_brightness_code         = main_code_q;
    assign aux_brightness_code          = aux_code_q;
    assign indicator_level_code         = ind_code_q;
    assign bus_busy                     = busy_q;

    // ==========================================================
    // checks, link domain
    property p_ack_one_pulse;
        @(negedge scl) disable iff (!link_rst_b)
        $rose(oe_q) |=> !oe_q;
    endproperty
    a_ack_one_pulse: assert property (p_ack_one_pulse) else $error("ack longer than one pulse");

    property p_addr_match;
        @(negedge scl) disable iff (!link_rst_b)
        (state_q == ldi_pkg::LDI_ADDR && byte_done && !start_ev &&
         sh_q == {ldi_pkg::LDI_DEV_ADDR, 1'b0}) |=> (oe_q && state_q == ldi_pkg::LDI_ADDR_ACK);
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("own address not acked");

    property p_addr_miss;
        @(negedge scl) disable iff (!link_rst_b)
        (state_q == ldi_pkg::LDI_ADDR && byte_done && !start_ev &&
         sh_q[7:1] != ldi_pkg::LDI_DEV_ADDR) |=> (!oe_q && state_q == ldi_pkg::LDI_IGNORE);
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

    property p_read_refused;
        @(negedge scl) disable iff (!link_rst_b)
        (state_q == ldi_pkg::LDI_ADDR && byte_done && !start_ev && sh_q[0])
        |=> !oe_q ##1 !oe_q;
    endproperty
    a_read_refused: assert property (p_read_refused) else $error("read request acked");

    property p_restart;
        @(negedge scl) disable iff (!link_rst_b)
        start_ev |=> (state_q == ldi_pkg::LDI_ADDR && !oe_q);
    endproperty
    a_restart: assert property (p_restart) else $error("start did not restart address");

    property p_reg_select;
        @(negedge scl) disable iff (!link_rst_b)
        (state_q == ldi_pkg::LDI_REG && byte_done && !start_ev) |=> (reg_sel_q == $past(sh_q));
    endproperty
    a_reg_select: assert property (p_reg_select) else $error("register select lost");

    // ==========================================================
    // checks, system domain
    property p_busy_on_start;
        @(posedge clk) disable iff (!rst_b)
        (ce && start_det) |=> busy_q;
    endproperty
    a_busy_on_start: assert property (p_busy_on_start) else $error("start left bus free");

    property p_free_on_stop;
        @(posedge clk) disable iff (!rst_b)
        (ce && stop_det) |=> !busy_q;
    endproperty
    a_free_on_stop: assert property (p_free_on_stop) else $error("stop left bus busy");

    property p_gp_write;
        @(posedge clk) disable iff (!rst_b)
        (ce && wr_pulse && wr_addr_q == ldi_pkg::LDI_REG_GENERAL)
        |=> (gp_en_q == $past(wr_data_q[ldi_pkg::LDI_GP_EN_W-1:0]));
    endproperty
    a_gp_write: assert property (p_gp_write) else $error("general register not written");

    property p_reset_values;
        @(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> (gp_en_q == 5'h00 && main_code_q == 5'h00 &&
                          aux_code_q == 5'h00 && ind_code_q == 2'h0);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("wrong power-on value");

    property p_filter;
        @(posedge clk) disable iff (!rst_b)
        $changed(sda_f_q) |-> ($past(sda_h_q) == {FILT_LEN{sda_f_q}});
    endproperty
    a_filter: assert property (p_filter) else $error("unfiltered data change");

endmodule : ldi_led_i2c_target

// *** ldi_pkg.sv ***
// constants, register map and link states of the led driver serial target
package ldi_pkg;

    // ==========================================================
    // target address and register offsets
    localparam logic [6:0] LDI_DEV_ADDR     = 7'h36;
    localparam logic [7:0] LDI_REG_GENERAL  = 8'h10;
    localparam logic [7:0] LDI_REG_BANK_A   = 8'hA0;
    localparam logic [7:0] LDI_REG_BANK_B   = 8'hB0;
    localparam logic [7:0] LDI_REG_BANK_C   = 8'hC0;

    // ==========================================================
    // power-on values
    localparam logic [7:0] LDI_RST_GENERAL  = 8'h20;
    localparam logic [7:0] LDI_RST_BANK_A   = 8'hE0;
    localparam logic [7:0] LDI_RST_BANK_B   = 8'hE0;
    localparam logic [7:0] LDI_RST_BANK_C   = 8'hFC;

    // ==========================================================
    // field layout of the general enable register
    localparam int         LDI_GP_MAIN_BIT  = 0;
    localparam int         LDI_GP_AUX_BIT   = 1;
    localparam int         LDI_GP_IND_BIT   = 2;
    localparam int         LDI_GP_SENSE_BIT = 3;
    localparam int         LDI_GP_THIRD_BIT = 4;
    localparam int         LDI_GP_EN_W      = 5;
    localparam logic [2:0] LDI_GP_FIXED     = 3'h1;  // bits 7..5 read 001
    localparam int         LDI_CODE_W       = 5;     // bank a/b brightness code
    localparam int         LDI_LEVEL_W      = 2;     // bank c level code

    // ==========================================================
    // link framing and line filter
    localparam logic [3:0] LDI_BYTE_BITS    = 4'h8;
    localparam logic [3:0] LDI_ACK_SLOT     = 4'h0;
    localparam int         LDI_FILT_LEN     = 3;

    // link states, gray from idle to data ack along the write path
    typedef enum logic [2:0] {
        LDI_IDLE     = 3'h0,
        LDI_ADDR     = 3'h1,
        LDI_ADDR_ACK = 3'h3,
        LDI_REG      = 3'h2,
        LDI_REG_ACK  = 3'h6,
        LDI_DATA     = 3'h7,
        LDI_DATA_ACK = 3'h5,
        LDI_IGNORE   = 3'h4
    } ldi_link_state_type;

endpackage : ldi_pkg

// *** ldi_master_model.sv ***
// serial bus master model driving clock and data towards the led driver target
`timescale 1ns/1ps

module ldi_master_model (
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda_line
);
    // ==========================================================
    // link timing: 160 ns bit period, long holds around conditions
    localparam time HALF = 80;
    localparam time HOLD = 600;  // long enough for the system-side filter

    // both lines released and still between frames
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic start_cond();
        #10;
        sda_drv = 1'b1;
        #HOLD;
        scl = 1'b1;
        #HOLD;
        sda_drv = 1'b0;
        #HOLD;
        scl = 1'b0;
        #HOLD;
    endtask : start_cond

    // msb first, data moves while clock low
    task automatic send_bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            #10;
            sda_drv = b[i];
            #70;
            scl = 1'b1;
            #HALF;
            scl = 1'b0;
        end
    endtask : send_bits

    // data released over the ninth pulse
    task automatic send_byte(input logic [7:0] b, output logic ack);
        send_bits(b, 8);
        #10;
        sda_drv = 1'b1;
        #70;
        scl = 1'b1;
        #40;
        ack = ~sda_line;
        #40;
        scl = 1'b0;
    endtask : send_byte

    task automatic stop_cond();
        #10;
        sda_drv = 1'b0;
        #HOLD;
        scl = 1'b1;
        #HOLD;
        sda_drv = 1'b1;
        #HOLD;
    endtask : stop_cond

    // idle clock pulses with data high, used around reset
    task automatic pulse_idle(input int n);
        repeat (n) begin
            #HALF;
            scl = 1'b0;
            #HALF;
            scl = 1'b1;
        end
    endtask : pulse_idle

endmodule : ldi_master_model

// *** tb_top.sv ***
// self-checking testbench of the led driver serial target
`timescale 1ns/1ps

module tb_top;
    // ==========================================================
    // signals, model state and counters
    logic       clk;
    logic       rst_b;
    logic       ce;
    logic       scl;
    logic       sda_drv;
    wire        sda_line;
    logic       sda_o;
    logic       sda_oe;
    logic       bus_busy;
    logic       main_en;
    logic       aux_en;
    logic       ind_en;
    logic       sense_en;
    logic       third_en;
    logic [4:0] main_code;
    logic [4:0] aux_code;
    logic [1:0] ind_level;
    logic [6:0] bad_dev;
    logic       a;
    int         num_errors;
    int         n_tests;
    int         exp_gp;
    int         exp_a;
    int         exp_b;
    int         exp_c;
    logic [7:0] sel_tab [8] = '{8'h10, 8'hA0, 8'hB0, 8'hC0, 8'h20, 8'hA1, 8'h10, 8'h10};

    // pulled-up wired-and data line
    assign sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);

    // system clock
    initial clk = 1'b0;
    always #50 clk = ~clk;

    ldi_led_i2c_target ldi_led_i2c_target_inst (
        .clk                          (clk),
        .rst_b                        (rst_b),
        .ce                           (ce),
        .scl                          (scl),
        .sda_i                        (sda_line),
        .sda_o                        (sda_o),
        .sda_oe                       (sda_oe),
        .bus_busy                     (bus_busy),
        .main_display_sink_enable     (main_en),
        .aux_lighting_sink_enable     (aux_en),
        .indicator_sink_enable        (ind_en),
        .fifth_main_sink_sense_enable (sense_en),
        .third_aux_sink_enable        (third_en),
        .main_brightness_code         (main_code),
        .aux_brightness_code          (aux_code),
        .indicator_level_code         (ind_level)
    );

    ldi_master_model ldi_master_model_inst (
        .scl      (scl),
        .sda_drv  (sda_drv),
        .sda_line (sda_line)
    );

    // ==========================================================
    // compare, model and closing tasks
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check8

    task automatic model_reset();
        exp_gp = 8'h20;
        exp_a  = 8'hE0;
        exp_b  = 8'hE0;
        exp_c  = 8'hFC;
    endtask : model_reset

    task automatic model_write(input logic [7:0] sel, input logic [7:0] val);
        case (sel)
            8'h10: exp_gp = (val & 8'h1F) | 8'h20;
            8'hA0: exp_a = val;
            8'hB0: exp_b = val;
            8'hC0: exp_c = val;
            default: ;
        endcase
    endtask : model_write

    task automatic check_outputs();
        check8({3'h0, third_en, sense_en, ind_en, aux_en, main_en}, 8'(exp_gp) & 8'h1F);
        check8({3'h0, main_code}, 8'(exp_a) & 8'h1F);
        check8({3'h0, aux_code}, 8'(exp_b) & 8'h1F);
        check8({6'h0, ind_level}, 8'(exp_c) & 8'h03);
    endtask : check_outputs

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // ==========================================================
    // bus sequences
    task automatic apply_reset(input string name);
        @(posedge clk);
        rst_b <= 1'b0;
        ldi_master_model_inst.pulse_idle(3);
        @(negedge clk);
        check8({6'h0, sda_oe, bus_busy}, 8'h00);
        model_reset();
        check_outputs();
        @(posedge clk);
        rst_b <= 1'b1;
        ldi_master_model_inst.pulse_idle(2);
        repeat (6) @(posedge clk);
        $display("test %s done", name);
    endtask : apply_reset

    task automatic wr_body(input logic [6:0] dev, input logic [7:0] sel, input logic [7:0] val);
        logic ok;
        ok = (dev == 7'h36);
        ldi_master_model_inst.start_cond();
        @(negedge clk);
        check8({7'h0, bus_busy}, 8'h01);
        ldi_master_model_inst.send_byte({dev, 1'b0}, a);
        check8({7'h0, a}, {7'h0, ok});
        ldi_master_model_inst.send_byte(sel, a);
        check8({7'h0, a}, {7'h0, ok});
        @(negedge clk);
        check8({7'h0, bus_busy}, 8'h01);
        ldi_master_model_inst.send_byte(val, a);
        check8({7'h0, a}, {7'h0, ok});
        if (ok) begin
            model_write(sel, val);
        end
    endtask : wr_body

    task automatic end_frame(input string name);
        ldi_master_model_inst.stop_cond();
        repeat (8) @(posedge clk);
        @(negedge clk);
        check8({7'h0, bus_busy}, 8'h00);
        check_outputs();
        $display("test %s done", name);
    endtask : end_frame

    // ==========================================================
    // main sequence
    initial begin
        rst_b      = 1'b0;
        ce         = 1'b1;
        num_errors = 0;
        n_tests    = 0;
        void'($urandom(52623));
        apply_reset("power_on");
        wr_body(7'h36, 8'h10, 8'hFF);
        end_frame("all_enables");
        for (int i = 0; i < 8; i++) begin
            wr_body(7'h36, sel_tab[i], 8'($urandom));
            end_frame("write");
        end
        bad_dev = 7'($urandom);
        if (bad_dev == 7'h36) begin
            bad_dev = 7'h37;
        end
        wr_body(bad_dev, 8'h10, 8'h1F);
        wr_body(7'h36, 8'hA0, 8'($urandom));
        end_frame("wrong_address");
        ldi_master_model_inst.start_cond();
        ldi_master_model_inst.send_byte({7'h36, 1'b1}, a);
        check8({7'h0, a}, 8'h00);
        wr_body(7'h36, 8'hB0, 8'($urandom));
        end_frame("read_refused");
        ldi_master_model_inst.start_cond();
        ldi_master_model_inst.send_byte({7'h36, 1'b0}, a);
        ldi_master_model_inst.send_byte(8'hC0, a);
        ldi_master_model_inst.send_bits(8'(exp_c) ^ 8'hFF, 4);
        wr_body(7'h36, 8'hA0, 8'($urandom));
        end_frame("abort");
        wr_body(7'h36, 8'hC0, 8'($urandom));
        ldi_master_model_inst.send_byte(8'($urandom), a);
        check8({7'h0, a}, 8'h00);
        end_frame("extra_byte");
        apply_reset("mid_reset");
        wr_body(7'h36, 8'h10, 8'h00);
        end_frame("all_disables");
        wrap_up();
    end

    // hang guard
    initial begin
        #2000000;
        num_errors++;
        wrap_up();
    end

endmodule : tb_top
